// file: rtl/pic_map.svh
// Purpose: Register map, field positions, reset values and codes for the
//          priority interrupt controller.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Included by bare name.
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

// ============================================================
// Register offsets
`define PIC_OFF_PENDING   8'h00
`define PIC_OFF_SERVICE   8'h04
`define PIC_OFF_MASK      8'h08
`define PIC_OFF_LEVEL     8'h0c
`define PIC_OFF_SETUP     8'h10
`define PIC_OFF_EOI       8'h14
`define PIC_SEL_BIT       4

// ============================================================
// Setup word fields
`define PIC_SETUP_DONE    0
`define PIC_SETUP_LEVEL   1
`define PIC_SETUP_BASE_HI 7
`define PIC_SETUP_BASE_LO 3

// ============================================================
// Level word fields
`define PIC_LEVEL_VALID   3

// ============================================================
// Reset values and fixed codes
`define PIC_MASK_RESET    8'hff
`define PIC_BASE_RESET    5'h00
`define PIC_SPURIOUS_LVL  3'h7
`define PIC_SRC_SERIAL    0
`define PIC_SRC_KEYBOARD  4
`define PIC_SRC_TIMER     5
`define PIC_SRC_FPU       7

`endif

// file: rtl/pic_pkg.sv
// Purpose: Shared types of the priority interrupt controller.
// Assumes: Nothing.
// Notes:   Use as pic_pkg::name.
package pic_pkg;
  typedef enum logic {
    PHASE_FIRST  = 1'b0,
    PHASE_SECOND = 1'b1
  } ack_phase_t;

  typedef enum logic {
    TRIG_EDGE  = 1'b0,
    TRIG_LEVEL = 1'b1
  } trig_mode_t;
endpackage : pic_pkg

// file: rtl/prio_pick.sv
// Purpose: Finds the highest-priority set bit, bit 0 ranking first.
// Assumes: Pure combinational.
// Notes:   Index is zero when nothing is set.
`timescale 1ns/10ps
module prio_pick #(
  parameter int WIDTH = 8,
  parameter int IDXW  = 3
) (
  input  wire logic [WIDTH-1:0] bits,
  output logic                  any,
  output logic [IDXW-1:0]       idx,
  output logic [WIDTH-1:0]      onehot
);
  logic [WIDTH:0] above;

  assign above[0] = 1'b0;
  assign any      = above[WIDTH];

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign above[i+1] = above[i] | bits[i];
      assign onehot[i]  = bits[i] & ~above[i];
    end
  endgenerate

  always_comb begin
    idx = '0;
    for (int k = WIDTH - 1; k >= 0; k--) begin
      if (bits[k]) begin
        idx = IDXW'(k);
      end
    end
  end
endmodule : prio_pick

// file: rtl/ack_toggle.sv
// Purpose: Tracks the two acknowledge pulses with a toggling flip-flop.
// Assumes: Acknowledge level already gated and synchronous to clk.
// Notes:   Toggles at the end of each gated pulse.
`timescale 1ns/10ps
module ack_toggle (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ack_now,
  output logic              first_start,
  output logic              second_start,
  output pic_pkg::ack_phase_t phase_q
);
  logic ack_q;
  logic ack_end;
  pic_pkg::ack_phase_t phase_d;

  assign first_start  = ack_now & ~ack_q & (phase_q == pic_pkg::PHASE_FIRST);
  assign second_start = ack_now & ~ack_q & (phase_q == pic_pkg::PHASE_SECOND);
  assign ack_end      = ~ack_now & ack_q;
  assign phase_d = ack_end ? pic_pkg::ack_phase_t'(~phase_q) : phase_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      phase_q <= pic_pkg::PHASE_FIRST;
    end else begin
      ack_q   <= ack_now;
      phase_q <= phase_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_toggle_flips: assert property (
    ack_q && !ack_now |=> phase_q != $past(phase_q))
    else $error("toggle did not flip at end of acknowledge");
  a_toggle_holds: assert property (
    ack_q == ack_now |=> phase_q == $past(phase_q))
    else $error("toggle moved without acknowledge end");
endmodule : ack_toggle

// file: rtl/priority_interrupt_controller.sv
// Purpose: Eight-input priority interrupt controller with APB registers
//          and a two-pulse acknowledge answer.
// Assumes: All pins synchronous to pclk; APB slave answers with no wait.
// Notes:   Vector and cascade buses are out/enable pairs.
//
// What this block does
// - Takes eight request inputs and ranks them, input 0 highest.
// - Board sources map to inputs 0, 4, 5 and 7.
// - Timer group request is the OR of five timer and serial sources.
// - Each input registers on a rising edge or a high level.
// - Active-low lines are inverted and set pending bits.
// - Highest pending bit goes to the same in-service bit.
// - Firmware mask removes pending bits from arbitration.
// - Interrupt output only when a pending request outranks all in service.
// - First acknowledge sets in-service, clears pending unless a level request still holds it, drives no data.
// - Second acknowledge drives the eight-bit vector on data bits 0-7.
// - A vanished request still yields the vector of input 7.
// - Toggle flip-flop flags the first acknowledge, no data moved.
// - Second acknowledge drives a three-bit cascade address.
// - Acknowledge counts only while this processor owns the bus.
// - Selected reads show registers or level; writes load command words.
// - Register-select bit picks interrupt or command registers.
// - No arbitration before firmware finishes set-up.
// - Vector-drive output asserted while data bits 0-7 are driven.
// - Buffer enable goes low while the chip has data to send.
// - Reset initialises all logic, toggle included.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "pic_map.svh"
module priority_interrupt_controller #(
  parameter int NREQ = 8,
  parameter int IDXW = 3
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NREQ-1:0] request_lines_n,
  input  wire logic            serial_rx_request_n,
  input  wire logic            keyboard_request_n,
  input  wire logic            bus_timeout_request_n,
  input  wire logic            fpu_error,
  input  wire logic            timer_one_out,
  input  wire logic            tx_empty_flag_n,
  input  wire logic            tx_ready_flag_n,
  input  wire logic            serial_status_change,
  input  wire logic            counter_zero_out,
  input  wire logic            irq_ack_strobe_n,
  input  wire logic            bus_master_enable_n,
  output logic                 cpu_irq_out,
  output logic                 first_ack_flag_n,
  output logic [7:0]           vector_data,
  output logic                 vector_data_oe,
  output logic                 onboard_vector_drive_n,
  output logic                 slave_buffer_enable_n,
  output logic [IDXW-1:0]      cascade_addr_lines,
  output logic                 cascade_addr_oe
);

  // ============================================================
  // Request gathering
  logic [NREQ-1:0] req_now;
  logic            timer_group_request;

  assign timer_group_request = timer_one_out | ~tx_empty_flag_n
                             | ~tx_ready_flag_n | serial_status_change
                             | counter_zero_out;

  genvar g;
  generate
    for (g = 0; g < NREQ; g++) begin : g_req
      if (g == `PIC_SRC_SERIAL) begin : g_ser
        assign req_now[g] = ~request_lines_n[g] | ~serial_rx_request_n;
      end else if (g == `PIC_SRC_KEYBOARD) begin : g_kb
        assign req_now[g] = ~request_lines_n[g] | ~keyboard_request_n;
      end else if (g == `PIC_SRC_TIMER) begin : g_tm
        assign req_now[g] = ~request_lines_n[g] | ~bus_timeout_request_n
                          | timer_group_request;
      end else if (g == `PIC_SRC_FPU) begin : g_fpu
        assign req_now[g] = ~request_lines_n[g] | fpu_error;
      end else begin : g_plain
        assign req_now[g] = ~request_lines_n[g];
      end
    end
  endgenerate

  // ============================================================
  // State registers
  logic [NREQ-1:0] req_prev_q;
  logic [NREQ-1:0] pend_q;
  logic [NREQ-1:0] pend_d;
  logic [NREQ-1:0] isr_q;
  logic [NREQ-1:0] isr_d;
  logic [NREQ-1:0] mask_q;
  logic [4:0]      base_q;
  logic            init_done_q;
  pic_pkg::trig_mode_t mode_q;
  logic [IDXW-1:0] vec_level_q;

  // ============================================================
  // Arbitration
  logic [NREQ-1:0] cand;
  logic            req_any;
  logic [IDXW-1:0] req_idx;
  logic [NREQ-1:0] req_hot;
  logic            isr_any;
  logic [IDXW-1:0] isr_idx;
  logic [NREQ-1:0] isr_hot;
  logic            irq_want;

  assign cand = pend_q & ~mask_q;

  prio_pick #(.WIDTH(NREQ), .IDXW(IDXW)) u_pick_req (
    .bits   (cand),
    .any    (req_any),
    .idx    (req_idx),
    .onehot (req_hot)
  );

  prio_pick #(.WIDTH(NREQ), .IDXW(IDXW)) u_pick_isr (
    .bits   (isr_q),
    .any    (isr_any),
    .idx    (isr_idx),
    .onehot (isr_hot)
  );

  assign irq_want = init_done_q & req_any & (~isr_any | (req_idx < isr_idx));

  // ============================================================
  // Acknowledge handling
  logic                ack_now;
  logic                first_start;
  logic                second_start;
  pic_pkg::ack_phase_t phase_q;
  logic                take;
  logic [NREQ-1:0]     grant;

  assign ack_now = ~irq_ack_strobe_n & ~bus_master_enable_n;

  ack_toggle u_ack (
    .clk          (pclk),
    .rst_n        (presetn),
    .ack_now      (ack_now),
    .first_start  (first_start),
    .second_start (second_start),
    .phase_q      (phase_q)
  );

  assign take  = first_start & init_done_q;
  assign grant = (take & req_any) ? req_hot : '0;

  // ============================================================
  // APB decode
  logic        setup_ph;
  logic        wr_go;
  logic        cmd_sel;
  logic        hit;
  logic        wr_mask;
  logic        wr_setup;
  logic        wr_eoi;
  logic [31:0] rd_word;

  assign setup_ph = psel & ~penable;
  assign wr_go    = psel & penable & pready & pwrite;
  assign cmd_sel  = paddr[`PIC_SEL_BIT];
  assign hit      = (paddr == `PIC_OFF_PENDING) | (paddr == `PIC_OFF_SERVICE)
                  | (paddr == `PIC_OFF_MASK)    | (paddr == `PIC_OFF_LEVEL)
                  | (paddr == `PIC_OFF_SETUP)   | (paddr == `PIC_OFF_EOI);
  assign wr_mask  = wr_go & ~cmd_sel & (paddr == `PIC_OFF_MASK);
  assign wr_setup = wr_go & cmd_sel & (paddr == `PIC_OFF_SETUP);
  assign wr_eoi   = wr_go & cmd_sel & (paddr == `PIC_OFF_EOI);

  always_comb begin
    rd_word = '0;
    unique case (paddr)
      `PIC_OFF_PENDING: rd_word[NREQ-1:0] = pend_q;
      `PIC_OFF_SERVICE: rd_word[NREQ-1:0] = isr_q;
      `PIC_OFF_MASK:    rd_word[NREQ-1:0] = mask_q;
      `PIC_OFF_LEVEL: begin
        rd_word[IDXW-1:0]        = isr_idx;
        rd_word[`PIC_LEVEL_VALID] = isr_any;
      end
      `PIC_OFF_SETUP: begin
        rd_word[`PIC_SETUP_BASE_HI:`PIC_SETUP_BASE_LO] = base_q;
        rd_word[`PIC_SETUP_LEVEL] = mode_q;
        rd_word[`PIC_SETUP_DONE]  = init_done_q;
      end
      default: rd_word = '0;
    endcase
  end

  // ============================================================
  // Pending and in-service next state
  generate
    for (g = 0; g < NREQ; g++) begin : g_pend
      logic set_b;
      logic clr_b;
      assign set_b = init_done_q & req_now[g]
                   & ((mode_q == pic_pkg::TRIG_LEVEL) | ~req_prev_q[g]);
      assign clr_b = grant[g]
                   | ((mode_q == pic_pkg::TRIG_LEVEL) & ~req_now[g]);
      assign pend_d[g] = set_b | (pend_q[g] & ~clr_b);
      assign isr_d[g]  = grant[g]
                       | (isr_q[g] & ~(wr_eoi & isr_hot[g]));
    end
  endgenerate

  // ============================================================
  // Core registers
  // reset everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_prev_q <= '0;
      pend_q     <= '0;
      isr_q      <= '0;
    end else begin
      req_prev_q <= req_now;
      pend_q     <= pend_d;
      isr_q      <= isr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q      <= `PIC_MASK_RESET;
      base_q      <= `PIC_BASE_RESET;
      mode_q      <= pic_pkg::TRIG_EDGE;
      init_done_q <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask_q <= pwdata[NREQ-1:0];
      end
      if (wr_setup) begin
        base_q      <= pwdata[`PIC_SETUP_BASE_HI:`PIC_SETUP_BASE_LO];
        mode_q      <= pic_pkg::trig_mode_t'(pwdata[`PIC_SETUP_LEVEL]);
        init_done_q <= pwdata[`PIC_SETUP_DONE];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_level_q <= `PIC_SPURIOUS_LVL;
    end else if (first_start) begin
      vec_level_q <= (take & req_any) ? req_idx : `PIC_SPURIOUS_LVL;
    end
  end

  // ============================================================
  // APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit;
      prdata  <= (setup_ph & ~pwrite) ? rd_word : '0;
    end
  end

  // ============================================================
  // Processor-side outputs
  logic drive_second;
  assign drive_second = ack_now & (phase_q == pic_pkg::PHASE_SECOND);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_out            <= 1'b0;
      first_ack_flag_n       <= 1'b1;
      vector_data            <= '0;
      vector_data_oe         <= 1'b0;
      onboard_vector_drive_n <= 1'b1;
      slave_buffer_enable_n  <= 1'b1;
      cascade_addr_lines     <= '0;
      cascade_addr_oe        <= 1'b0;
    end else begin
      cpu_irq_out      <= irq_want;
      first_ack_flag_n <= ~(ack_now & (phase_q == pic_pkg::PHASE_FIRST));
      vector_data      <= {base_q, vec_level_q};
      vector_data_oe   <= drive_second;
      onboard_vector_drive_n <= ~drive_second;
      slave_buffer_enable_n  <= ~drive_second;
      cascade_addr_lines <= vec_level_q;
      cascade_addr_oe    <= drive_second;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_second_ack;
    ack_now && phase_q == pic_pkg::PHASE_SECOND;
  endsequence

  sequence s_first_ack;
    ack_now && phase_q == pic_pkg::PHASE_FIRST;
  endsequence

  a_irq_when_outranks: assert property (
    irq_want |=> cpu_irq_out)
    else $error("interrupt not raised for outranking request");
  a_irq_before_setup: assert property (
    !init_done_q |=> !cpu_irq_out)
    else $error("interrupt raised before set-up");
  a_mask_blocks_irq: assert property (
    (pend_q & ~mask_q) == '0 |=> !cpu_irq_out)
    else $error("masked request raised interrupt");
  a_first_sets_isr: assert property (
    take && req_any |=> isr_q[$past(req_idx)] && vec_level_q == $past(req_idx))
    else $error("first acknowledge did not set in-service bit");
  a_spurious_vec: assert property (
    first_start && !(take && req_any) |=> vec_level_q == `PIC_SPURIOUS_LVL)
    else $error("vanished request not given level seven");
  a_first_no_drive: assert property (
    s_first_ack |=> !first_ack_flag_n && !vector_data_oe && !cascade_addr_oe)
    else $error("first acknowledge moved data or lacked flag");
  a_second_drives: assert property (
    s_second_ack ##1 s_second_ack |-> vector_data_oe && cascade_addr_oe
      && !onboard_vector_drive_n && !slave_buffer_enable_n
      && vector_data[IDXW-1:0] == vec_level_q)
    else $error("second acknowledge failed to drive vector");
  a_bme_gates_ack: assert property (
    bus_master_enable_n |=> first_ack_flag_n && !vector_data_oe)
    else $error("acknowledge honoured without bus ownership");
  a_eoi_clears: assert property (
    wr_eoi && isr_any && !take |=> !isr_q[$past(isr_idx)])
    else $error("end of interrupt left in-service bit set");
  a_isr_sticky: assert property (
    isr_q != '0 && !wr_eoi |=> (isr_q & $past(isr_q)) == $past(isr_q))
    else $error("in-service bit dropped without end of interrupt");
endmodule : priority_interrupt_controller

// file: verification/host_cpu_model.sv
// Purpose: Host processor model that answers interrupts with two acks.
// Assumes: Starts only after a clock edge; design outputs are registered.
// Notes:   slow stretches each acknowledge pulse by that many cycles.
`timescale 1ns/10ps
module host_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cpu_irq_out,
  input  wire logic       first_ack_flag_n,
  input  wire logic [7:0] vector_data,
  input  wire logic       vector_data_oe,
  input  wire logic       onboard_vector_drive_n,
  input  wire logic       slave_buffer_enable_n,
  input  wire logic [2:0] cascade_addr_lines,
  input  wire logic       cascade_addr_oe,
  input  wire logic       auto_ack,
  input  wire logic       start_ack,
  input  wire logic [1:0] slow,
  output logic            irq_ack_strobe_n,
  output logic [7:0]      acks_done,
  output logic [7:0]      vec_q,
  output logic [5:0]      aux_q,
  output logic            flag_seen,
  output logic            vec_seen
);
  // ============================================================
  // One low acknowledge pulse, then at least one idle cycle
  task ack_pulse(input logic second);
    irq_ack_strobe_n <= 1'b0;
    repeat (2 + slow) begin
      @(posedge pclk);
      if (!second && first_ack_flag_n === 1'b0 && vector_data_oe === 1'b0)
        flag_seen <= 1'b1;
      if (second && vector_data_oe === 1'b1) begin
        vec_seen <= 1'b1;
        vec_q    <= vector_data;
        aux_q    <= {cascade_addr_oe, onboard_vector_drive_n,
                     slave_buffer_enable_n, cascade_addr_lines};
      end
    end
    irq_ack_strobe_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : ack_pulse

  // ============================================================
  // Sequencer
  initial begin
    irq_ack_strobe_n = 1'b1;
    acks_done        = 8'h00;
    vec_q            = 8'h00;
    aux_q            = 6'h00;
    flag_seen        = 1'b0;
    vec_seen         = 1'b0;
    forever begin
      @(posedge pclk);
      if (presetn === 1'b1 && (start_ack === 1'b1 ||
          (auto_ack === 1'b1 && cpu_irq_out === 1'b1))) begin
        flag_seen <= 1'b0;
        vec_seen  <= 1'b0;
        ack_pulse(1'b0);
        ack_pulse(1'b1);
        acks_done <= acks_done + 8'h01;
      end
    end
  end
endmodule : host_cpu_model

// file: verification/testbench.sv
// Purpose: Self-checking bench for the priority interrupt controller.
// Assumes: APB answers within a few cycles; host model gives the acks.
// Notes:   Vector base 5'h15 throughout.
`timescale 1ns/10ps
`include "pic_map.svh"
module testbench;
  localparam logic [4:0] BASE = 5'h15;
  localparam logic [7:0] LVL  = {BASE, 3'b011};
  localparam logic [7:0] EDG  = {BASE, 3'b001};
  function automatic logic [2:0] src_idx(input int i);
    if (i < 8) return i[2:0];
    if (i == 8) return 3'(`PIC_SRC_SERIAL);
    if (i == 9) return 3'(`PIC_SRC_KEYBOARD);
    if (i == 11) return 3'(`PIC_SRC_FPU);
    return 3'(`PIC_SRC_TIMER);
  endfunction : src_idx
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  request_lines_n, vector_data, acks_done, vec_q, na;
  logic        serial_rx_request_n, keyboard_request_n, fpu_error;
  logic        bus_timeout_request_n, timer_one_out, tx_empty_flag_n;
  logic        tx_ready_flag_n, serial_status_change, counter_zero_out;
  logic        irq_ack_strobe_n, bus_master_enable_n, cpu_irq_out;
  logic        first_ack_flag_n, vector_data_oe, onboard_vector_drive_n;
  logic        slave_buffer_enable_n, cascade_addr_oe, last_err;
  logic        auto_ack, start_ack, flag_seen, vec_seen;
  logic [2:0]  cascade_addr_lines;
  logic [1:0]  slow;
  logic [5:0]  aux_q;
  int          mismatches, checks_done;

  priority_interrupt_controller u_dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .request_lines_n, .serial_rx_request_n, .keyboard_request_n,
    .bus_timeout_request_n, .fpu_error, .timer_one_out, .tx_empty_flag_n,
    .tx_ready_flag_n, .serial_status_change, .counter_zero_out,
    .irq_ack_strobe_n, .bus_master_enable_n, .cpu_irq_out,
    .first_ack_flag_n, .vector_data, .vector_data_oe,
    .onboard_vector_drive_n, .slave_buffer_enable_n, .cascade_addr_lines,
    .cascade_addr_oe);
  host_cpu_model u_host (.pclk, .presetn, .cpu_irq_out, .first_ack_flag_n,
    .vector_data, .vector_data_oe, .onboard_vector_drive_n,
    .slave_buffer_enable_n, .cascade_addr_lines, .cascade_addr_oe,
    .auto_ack, .start_ack, .slow, .irq_ack_strobe_n, .acks_done, .vec_q,
    .aux_q, .flag_seen, .vec_seen);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ============================================================
  // Helpers
  task end_sim;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    int n;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wd;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      end_sim;
    end
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    apb(1'b0, a, 32'h0, d);
    chk(nm, d, e);
  endtask : rd

  task set_src(input int i, input logic on);
    if (i < 8) request_lines_n[i] <= ~on;
    case (i)
      8: serial_rx_request_n <= ~on;
      9: keyboard_request_n <= ~on;
      10: bus_timeout_request_n <= ~on;
      11: fpu_error <= on;
      12: timer_one_out <= on;
      13: tx_empty_flag_n <= ~on;
      14: tx_ready_flag_n <= ~on;
      15: serial_status_change <= on;
      16: counter_zero_out <= on;
      default: ;
    endcase
  endtask : set_src

  task pulse_src(input int i);
    set_src(i, 1'b1);
    repeat (2) @(posedge pclk);
    set_src(i, 1'b0);
  endtask : pulse_src

  task wait_irq(input logic v);
    for (int n = 0; cpu_irq_out !== v && n < 30; n++) @(posedge pclk);
    chk("irq", cpu_irq_out, v);
    if (cpu_irq_out !== v) end_sim;
  endtask : wait_irq

  task do_ack(input logic f, input logic [2:0] idx, input logic own);
    if (f) start_ack <= 1'b1;
    else auto_ack <= 1'b1;
    @(posedge pclk);
    start_ack <= 1'b0;
    auto_ack  <= 1'b0;
    na = na + 8'h01;
    for (int n = 0; acks_done !== na && n < 200; n++) @(posedge pclk);
    if (acks_done !== na) begin
      mismatches++;
      end_sim;
    end
    chk("first flag", flag_seen, own);
    chk("vector seen", vec_seen, own);
    if (own) begin
      chk("vector", vec_q, {BASE, idx});
      chk("drives", aux_q, {3'b100, idx});
    end
  endtask : do_ack

  // ============================================================
  // Scenarios
  task t_reset;
    chk("irq", cpu_irq_out, 1'b0);
    chk("flag", first_ack_flag_n, 1'b1);
    chk("oe", {vector_data_oe, cascade_addr_oe, onboard_vector_drive_n,
               slave_buffer_enable_n}, 4'b0011);
    rd(`PIC_OFF_MASK, 32'hff, "mask");
    rd(`PIC_OFF_SETUP, 32'h0, "setup");
    rd(`PIC_OFF_EOI, 32'h0, "eoi");
    rd(8'h18, 32'h0, "unmapped");
    chk("slverr", last_err, 1'b1);
  endtask : t_reset

  task t_init_mask;
    wr(`PIC_OFF_MASK, 32'h0);
    set_src(0, 1'b1);
    repeat (5) @(posedge pclk);
    chk("irq", cpu_irq_out, 1'b0);
    rd(`PIC_OFF_PENDING, 32'h0, "pend");
    wr(`PIC_OFF_SETUP, LVL);
    wait_irq(1'b1);
    wr(`PIC_OFF_MASK, 32'h1);
    wait_irq(1'b0);
    wr(`PIC_OFF_MASK, 32'h0);
    wait_irq(1'b1);
    do_ack(1'b0, 3'h0, 1'b1);
    set_src(0, 1'b0);
    wr(`PIC_OFF_EOI, 32'h0);
  endtask : t_init_mask

  task t_sources;
    for (int i = 0; i < 17; i++) begin
      set_src(i, 1'b1);
      wait_irq(1'b1);
      do_ack(1'b0, src_idx(i), 1'b1);
      rd(`PIC_OFF_SERVICE, 32'h1 << src_idx(i), "isr");
      chk("irq", cpu_irq_out, 1'b0);
      set_src(i, 1'b0);
      wr(`PIC_OFF_EOI, 32'h0);
      rd(`PIC_OFF_SERVICE, 32'h0, "isr");
    end
  endtask : t_sources

  task t_edge_prio;
    wr(`PIC_OFF_SETUP, EDG);
    pulse_src(3);
    wait_irq(1'b1);
    rd(`PIC_OFF_PENDING, 32'h08, "pend");
    do_ack(1'b0, 3'h3, 1'b1);
    rd(`PIC_OFF_PENDING, 32'h0, "pend");
    pulse_src(5);
    repeat (4) @(posedge pclk);
    chk("irq", cpu_irq_out, 1'b0);
    rd(`PIC_OFF_PENDING, 32'h20, "pend");
    pulse_src(1);
    wait_irq(1'b1);
    rd(`PIC_OFF_LEVEL, 32'h0b, "level");
    do_ack(1'b0, 3'h1, 1'b1);
    rd(`PIC_OFF_SERVICE, 32'h0a, "isr");
    wr(`PIC_OFF_EOI, 32'h0);
    rd(`PIC_OFF_SERVICE, 32'h08, "isr");
    wr(`PIC_OFF_EOI, 32'h0);
    wait_irq(1'b1);
    do_ack(1'b0, 3'h5, 1'b1);
    wr(`PIC_OFF_EOI, 32'h0);
  endtask : t_edge_prio

  task t_spurious;
    do_ack(1'b1, 3'h7, 1'b1);
    rd(`PIC_OFF_SERVICE, 32'h0, "isr");
  endtask : t_spurious

  task t_bus_owner;
    slow                <= 2'd2;
    bus_master_enable_n <= 1'b1;
    pulse_src(2);
    wait_irq(1'b1);
    do_ack(1'b1, 3'h2, 1'b0);
    chk("irq", cpu_irq_out, 1'b1);
    bus_master_enable_n <= 1'b0;
    do_ack(1'b0, 3'h2, 1'b1);
    wr(`PIC_OFF_EOI, 32'h0);
  endtask : t_bus_owner

  // ============================================================
  // Main sequence
  initial begin
    mismatches            = 0;
    checks_done           = 0;
    na                    = 8'h00;
    presetn               = 1'b0;
    psel                  = 1'b0;
    penable               = 1'b0;
    pwrite                = 1'b0;
    paddr                 = 8'h00;
    pwdata                = 32'h0;
    request_lines_n       = 8'hff;
    serial_rx_request_n   = 1'b1;
    keyboard_request_n    = 1'b1;
    bus_timeout_request_n = 1'b1;
    fpu_error             = 1'b0;
    timer_one_out         = 1'b0;
    tx_empty_flag_n       = 1'b1;
    tx_ready_flag_n       = 1'b1;
    serial_status_change  = 1'b0;
    counter_zero_out      = 1'b0;
    bus_master_enable_n   = 1'b0;
    auto_ack              = 1'b0;
    start_ack             = 1'b0;
    slow                  = 2'd0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_init_mask;
    t_sources;
    t_edge_prio;
    t_spurious;
    t_bus_owner;
    end_sim;
  end
endmodule : testbench
